// file: hw/pipe_control_register.sv
// Purpose: control and status registers of pipes one to four
// Assumes: engine and FIFO events arrive on ref_clk, one cycle each
// Notes: read data appear the cycle after the read strobe
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

`include "pipe_ctrl_map.svh"

module pipe_control_register (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  output logic [15:0] busRdData,
  input wire pipe_ctrl_pkg::pipe_evt_s [3:0] pipeEvt,
  input wire logic busResetSeen,
  output pipe_ctrl_pkg::answer_e [3:0] pipeAnswer,
  output logic [3:0] notReadyEvt,
  output logic [3:0] toggleExpected,
  output logic [3:0] bufferInit
);

  // one-hot pipe select for an address, zero when unmapped
  function automatic logic [3:0] pipeHit(input logic [7:0] addr);
    logic [3:0] hit;
    hit = 4'h0;
    unique case (addr)
      `PCR_PIPE1_OFS: hit = 4'h1;
      `PCR_PIPE2_OFS: hit = 4'h2;
      `PCR_PIPE3_OFS: hit = 4'h4;
      `PCR_PIPE4_OFS: hit = 4'h8;
      default: hit = 4'h0;
    endcase
    return hit;
  endfunction : pipeHit

  // decoded write and read selects
  logic [3:0] wrHit;
  logic [3:0] rdHit;

  // software-owned control bits
  logic [3:0] autoReply; // auto-reply enable per pipe
  logic [3:0] autoClear; // buffer auto-clear enable per pipe

  // mixed-owned and hardware-owned state
  logic [1:0] respSel [4]; // response field per pipe
  logic [3:0] toggle; // expected data toggle
  logic [3:0] busy; // pipe in a bus transaction
  logic [3:0] pending; // registered transmit-data monitor
  logic [3:0] ready; // buffer-ready flags

  // assembled read words
  logic [15:0] readWord [4];
  logic [15:0] next_rdData;

  // address decode, shared by write and read paths
  always_comb begin
    wrHit = busWrStb ? pipeHit(busAddr) : 4'h0;
    rdHit = busRdStb ? pipeHit(busAddr) : 4'h0;
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : gPipe

      // buffer-ready flag, emptied while auto-clear is on and no set arrives
      pipe_ready_flag uReady (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .evt(pipeEvt[p]),
        .flush(autoClear[p]),
        .ready(ready[p])
      );

      // software control bits of this pipe
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          autoReply[p] <= 1'b0;
          autoClear[p] <= 1'b0;
        end else if (wrHit[p]) begin
          // plain read/write enables
          autoReply[p] <= busWrData[`PCR_AUTOREPLY_BIT];
          autoClear[p] <= busWrData[`PCR_AUTOCLEAR_BIT];
        end
      end

      // response field: hardware writes win over software
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          respSel[p] <= `PCR_RESP_RESET;
        end else if (pipeEvt[p].oversize) begin
          // oversized payload forces the second STALL code
          respSel[p] <= `PCR_RESP_STALL_B;
        end else if (busResetSeen) begin
          // bus reset returns the pipe to NAK
          respSel[p] <= `PCR_RESP_NAK;
        end else if (wrHit[p]) begin
          // software may write any code, ordering is its duty
          respSel[p] <= busWrData[`PCR_RESP_HI:`PCR_RESP_LO];
        end
      end

      // expected toggle: forced by software, flipped on success
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          toggle[p] <= 1'b0;
        end else if (wrHit[p] && busWrData[`PCR_FORCE0_BIT]) begin
          // force to DATA0, a zero written does nothing
          toggle[p] <= 1'b0;
        end else if (wrHit[p] && busWrData[`PCR_FORCE1_BIT]) begin
          // force to DATA1, a zero written does nothing
          toggle[p] <= 1'b1;
        end else if (pipeEvt[p].txnGood) begin
          // good transaction moves to the other toggle
          toggle[p] <= ~toggle[p];
        end
      end

      // busy flag: a start in the end cycle keeps it set
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          busy[p] <= 1'b0;
        end else if (pipeEvt[p].txnStart) begin
          busy[p] <= 1'b1;
        end else if (pipeEvt[p].txnDone) begin
          busy[p] <= 1'b0;
        end
      end

      // transmit monitor; on receive it follows the ready flag
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pending[p] <= 1'b0;
        end else if (autoClear[p]) begin
          // auto-clear empties both halves of the buffer
          pending[p] <= 1'b0;
        end else begin
          pending[p] <= pipeEvt[p].txDataPending;
        end
      end

      // handshake for the next token, from field and mode
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pipeAnswer[p] <= pipe_ctrl_pkg::ANS_NAK;
        end else begin
          unique case (respSel[p])
            // nak code
            `PCR_RESP_NAK: begin
              pipeAnswer[p] <= pipe_ctrl_pkg::ANS_NAK;
            end
            // buffer code, bent by auto-reply
            `PCR_RESP_BUF: begin
              if (!autoReply[p]) begin
                pipeAnswer[p] <= pipe_ctrl_pkg::ANS_DATA;
              end else if (pipeEvt[p].dirTx) begin
                pipeAnswer[p] <= pipe_ctrl_pkg::ANS_ZLP;
              end else begin
                pipeAnswer[p] <= pipe_ctrl_pkg::ANS_NAK;
              end
            end
            // both upper codes stall
            `PCR_RESP_STALL_A, `PCR_RESP_STALL_B: begin
              pipeAnswer[p] <= pipe_ctrl_pkg::ANS_STALL;
            end
          endcase
        end
      end

      // not-ready pulse for a receive token under auto-reply
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          notReadyEvt[p] <= 1'b0;
        end else begin
          notReadyEvt[p] <= pipeEvt[p].tokenSeen
            && autoReply[p] && !pipeEvt[p].dirTx
            && (respSel[p] == `PCR_RESP_BUF);
        end
      end

      // outward copies of toggle and buffer initialise
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          toggleExpected[p] <= 1'b0;
          bufferInit[p] <= 1'b0;
        end else begin
          toggleExpected[p] <= toggle[p];
          bufferInit[p] <= autoClear[p];
        end
      end

      // read word; unassigned and force bits stay zero
      always_comb begin
        readWord[p] = `PCR_RDATA_RESET;
        readWord[p][`PCR_READY_BIT] = ready[p];
        // on receive the monitor mirrors the ready flag
        readWord[p][`PCR_PENDING_BIT] =
          pipeEvt[p].dirTx ? pending[p] : ready[p];
        readWord[p][`PCR_AUTOREPLY_BIT] = autoReply[p];
        readWord[p][`PCR_AUTOCLEAR_BIT] = autoClear[p];
        readWord[p][`PCR_TOGGLE_BIT] = toggle[p];
        readWord[p][`PCR_BUSY_BIT] = busy[p];
        readWord[p][`PCR_RESP_HI:`PCR_RESP_LO] = respSel[p];
      end

    end
  endgenerate

  // read mux; an unmapped address or idle cycle gives zero
  always_comb begin
    next_rdData = `PCR_RDATA_RESET;
    for (int i = 0; i < 4; i++) begin
      if (rdHit[i]) begin
        next_rdData = readWord[i];
      end
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdData <= `PCR_RDATA_RESET;
    end else begin
      busRdData <= next_rdData;
    end
  end

endmodule : pipe_control_register

`default_nettype wire

// file: hw/pipe_ctrl_map.svh
// Purpose: address map, field positions and codes of the pipe control bank
// Assumes: 8-bit register address, 16-bit register data
// Notes: included by the main module, the property module and the bench
`ifndef PIPE_CTRL_MAP_SVH
`define PIPE_CTRL_MAP_SVH

// register offsets, one 16-bit register each
`define PCR_PIPE1_OFS 8'h70
`define PCR_PIPE2_OFS 8'h72
`define PCR_PIPE3_OFS 8'h74
`define PCR_PIPE4_OFS 8'h76

// field positions
`define PCR_READY_BIT 4'hF
`define PCR_PENDING_BIT 4'hE
`define PCR_AUTOREPLY_BIT 4'hA
`define PCR_AUTOCLEAR_BIT 4'h9
`define PCR_FORCE0_BIT 4'h8
`define PCR_FORCE1_BIT 4'h7
`define PCR_TOGGLE_BIT 4'h6
`define PCR_BUSY_BIT 4'h5
`define PCR_RESP_HI 4'h1
`define PCR_RESP_LO 4'h0

// response field codes
`define PCR_RESP_NAK 2'h0
`define PCR_RESP_BUF 2'h1
`define PCR_RESP_STALL_A 2'h2
`define PCR_RESP_STALL_B 2'h3

// reset values
`define PCR_RESP_RESET 2'h0
`define PCR_RDATA_RESET 16'h0000

`endif

// file: hw/pipe_ctrl_pkg.sv
// Purpose: types shared by the pipe control bank
// Assumes: four pipes
// Notes: field positions live in pipe_ctrl_map.svh
package pipe_ctrl_pkg;

  // per-pipe status and events from the engine and FIFO logic
  typedef struct packed {
    logic dirTx;           // pipe transmits
    logic readEndHandling; // read-end handling configured
    logic clearAfterRead;  // clear-after-read configured
    logic rxDataAvail;     // pulse: received data readable
    logic rxReadDone;      // pulse: received data fully read
    logic bufferClearCmd;  // pulse: software buffer clear
    logic txSpaceAvail;    // pulse: transmit data may be written
    logic txWriteDone;     // pulse: transmit data write done
    logic txDataPending;   // level: buffer holds sendable data
    logic txnStart;        // pulse: bus transaction begins
    logic txnDone;         // pulse: bus transaction ends
    logic txnGood;         // pulse: transaction ok, flip toggle
    logic tokenSeen;       // pulse: token addressed to pipe
    logic oversize;        // pulse: payload over max packet size
  } pipe_evt_s;

  // handshake the engine gives to the next token
  typedef enum logic [1:0] {
    ANS_NAK,
    ANS_DATA,
    ANS_ZLP,
    ANS_STALL
  } answer_e;

endpackage : pipe_ctrl_pkg

// file: hw/pipe_ready_flag.sv
// Purpose: buffer-ready flag of one pipe
// Assumes: event inputs are one-cycle pulses on ref_clk
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module pipe_ready_flag (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pipe_ctrl_pkg::pipe_evt_s evt,
  input wire logic flush,
  output logic ready
);

  // set and clear terms chosen by direction and read modes
  logic setReady;
  logic clrReady;

  // decode of the direction / read-end / clear-after-read combination
  always_comb begin
    if (evt.dirTx) begin
      // transmit: writable space, cleared by write completion
      setReady = evt.txSpaceAvail;
      clrReady = evt.txWriteDone;
    end else if (evt.readEndHandling && !evt.clearAfterRead) begin
      // read-end handling: held until the buffer clear command
      setReady = evt.rxDataAvail;
      clrReady = evt.bufferClearCmd;
    end else begin
      // basic receive, or both modes on: cleared by full read
      setReady = evt.rxDataAvail;
      clrReady = evt.rxReadDone;
    end
  end

  // flag register; a set wins over a flush in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready <= 1'b0;
    end else if (setReady) begin
      ready <= 1'b1;
    end else if (clrReady || flush) begin
      ready <= 1'b0;
    end
  end

endmodule : pipe_ready_flag

`default_nettype wire

// file: bench/pipe_ctrl_properties.sv
// Purpose: port assertions of the pipe control bank
// Assumes: one clock, async active-low reset
// Notes: bound into pipe_control_register
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctrl_map.svh"

module pipe_ctrl_properties (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  input wire logic [15:0] busRdData,
  input wire pipe_ctrl_pkg::pipe_evt_s [3:0] pipeEvt,
  input wire logic busResetSeen,
  input wire pipe_ctrl_pkg::answer_e [3:0] pipeAnswer,
  input wire logic [3:0] notReadyEvt,
  input wire logic [3:0] toggleExpected,
  input wire logic [3:0] bufferInit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // write strobe aimed at pipe one
  sequence s_wr1;
    busWrStb && busAddr == `PCR_PIPE1_OFS;
  endsequence
  a_idle_rd_zero: assert property (
    !$past(busRdStb) |-> busRdData == 16'h0000)
    else $error("read data not zero when idle");
  a_unused_bits: assert property (
    $past(busRdStb) |-> busRdData[13:11] == 3'h0 &&
    busRdData[8:7] == 2'h0 && busRdData[4:2] == 3'h0)
    else $error("unassigned bits read non-zero");
  a_force_zero: assert property (
    s_wr1 ##0 busWrData[8] |-> ##2 !toggleExpected[0])
    else $error("toggle not forced to zero");
  a_force_one: assert property (
    s_wr1 ##0 (busWrData[7] && !busWrData[8]) |-> ##2 toggleExpected[0])
    else $error("toggle not forced to one");
  a_flip_good: assert property (
    pipeEvt[0].txnGood && !busWrStb |->
    ##2 toggleExpected[0] != $past(toggleExpected[0]))
    else $error("toggle not flipped");
  a_clear_follow: assert property (
    s_wr1 |-> ##2 bufferInit[0] == $past(busWrData[9], 2))
    else $error("buffer init not following write");
  a_oversize_stall: assert property (
    pipeEvt[0].oversize |-> ##2 pipeAnswer[0] == pipe_ctrl_pkg::ANS_STALL)
    else $error("oversize not answered by stall");
  a_bus_reset_nak: assert property (
    busResetSeen && !pipeEvt[0].oversize |->
    ##2 pipeAnswer[0] == pipe_ctrl_pkg::ANS_NAK)
    else $error("bus reset not answered by nak");
  a_not_ready_token: assert property (
    notReadyEvt[0] |-> $past(pipeEvt[0].tokenSeen))
    else $error("not-ready event without token");
endmodule : pipe_ctrl_properties

bind pipe_control_register pipe_ctrl_properties i_props (
  .ref_clk, .arst_n, .busAddr, .busWrData, .busWrStb, .busRdStb,
  .busRdData, .pipeEvt, .busResetSeen, .pipeAnswer, .notReadyEvt,
  .toggleExpected, .bufferInit
);
`default_nettype wire

// file: bench/pipe_host_model.sv
// Purpose: usb host issuing one token and transaction
// Assumes: go is a one-cycle pulse
// Notes: slow stretches the transaction
`timescale 1ns/1ps
`default_nettype none

module pipe_host_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic slow,
  output pipe_ctrl_pkg::pipe_evt_s evt
);
  logic [2:0] left = 3'h0; // cycles until handshake
  initial evt = '0;
  // token starts it, acknowledge ends it
  always @(posedge ref_clk) begin
    evt <= '0;
    if (go) begin
      evt.tokenSeen <= 1'b1;
      evt.txnStart <= 1'b1;
      left <= slow ? 3'h5 : 3'h2;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
      evt.txnDone <= left == 3'h1;
      evt.txnGood <= left == 3'h1;
    end
  end
endmodule : pipe_host_model
`default_nettype wire

// file: bench/pipe_control_register_test.sv
// Purpose: self-checking bench of the pipe control bank
// Assumes: pipe1 receives, pipe2 transmits, pipe3 read-end
// Notes: inputs driven by non-blocking assignment at edges
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctrl_map.svh"

module pipe_control_register_test;
  logic ref_clk = 1'b0; // bank clock
  logic arst_n = 1'b0; // async reset
  logic [7:0] busAddr = 8'h00; // register address
  logic [15:0] busWrData = 16'h0000; // write data
  logic busWrStb = 1'b0; // write strobe
  logic busRdStb = 1'b0; // read strobe
  logic [15:0] busRdData; // read data
  logic busResetSeen = 1'b0; // usb bus reset pulse
  pipe_ctrl_pkg::pipe_evt_s [3:0] drv =
    {14'h0, 14'h1000, 14'h2000, 14'h0};
  pipe_ctrl_pkg::pipe_evt_s [3:0] pipeEvt; // merged events
  pipe_ctrl_pkg::pipe_evt_s hostEvt; // host events
  pipe_ctrl_pkg::answer_e [3:0] pipeAnswer; // token answers
  logic [3:0] notReadyEvt, toggleExpected, bufferInit;
  logic go = 1'b0; // host start
  logic slow = 1'b0; // host pace
  int nrCount = 0; // pipe1 not-ready pulses
  int n_errors = 0;
  int check_count = 0;
  logic [1:0] codes [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0] answers [5] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h0}; // enum order
  localparam logic [13:0] AVAIL = 14'h0400; // event masks
  localparam logic [13:0] RDONE = 14'h0200;
  localparam logic [13:0] CLRCMD = 14'h0100;
  localparam logic [13:0] SPACE = 14'h0080;
  localparam logic [13:0] WDONE = 14'h0040;
  localparam logic [13:0] OVER = 14'h0001;

  always #20 ref_clk = ~ref_clk;
  // host always talks to pipe1
  always_comb begin
    pipeEvt = drv;
    pipeEvt[0] = drv[0] | hostEvt;
  end
  always @(posedge ref_clk) if (notReadyEvt[0]) nrCount++;

  pipe_control_register i_dut (.ref_clk, .arst_n, .busAddr, .busWrData,
    .busWrStb, .busRdStb, .busRdData, .pipeEvt, .busResetSeen,
    .pipeAnswer, .notReadyEvt, .toggleExpected, .bufferInit);
  pipe_host_model i_host (.ref_clk, .go, .slow, .evt(hostEvt));

  task chk(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [15:0] d);
    @(posedge ref_clk) {busWrStb, busAddr, busWrData} <= {1'b1, a, d};
    @(posedge ref_clk) busWrStb <= 1'b0;
  endtask : wr
  task rd(logic [7:0] a, logic [15:0] e);
    @(posedge ref_clk) {busRdStb, busAddr} <= {1'b1, a};
    @(posedge ref_clk) busRdStb <= 1'b0;
    #1 chk("busRdData", busRdData, e);
  endtask : rd
  task ev(int p, logic [13:0] m);
    @(posedge ref_clk) drv[p] <= drv[p] | m;
    @(posedge ref_clk) drv[p] <= drv[p] & ~m;
  endtask : ev
  task host(logic s);
    @(posedge ref_clk) {go, slow} <= {1'b1, s};
    @(posedge ref_clk) go <= 1'b0;
  endtask : host
  task summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    repeat (2000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(`PCR_PIPE1_OFS + 8'(2 * i), 16'h0000);
      chk("pipeAnswer", 16'(pipeAnswer[i]), 16'h0000);
    end
    wr(8'h78, 16'hFFFF);
    rd(8'h78, 16'h0000);
    wr(`PCR_PIPE1_OFS, 16'hFFFE);
    rd(`PCR_PIPE1_OFS, 16'h0602);
    chk("bufferInit", 16'(bufferInit[0]), 16'h0001);
    foreach (codes[k]) begin
      wr(`PCR_PIPE1_OFS, {14'h0000, codes[k]});
      rd(`PCR_PIPE1_OFS, {14'h0000, codes[k]});
      chk("pipeAnswer", 16'(pipeAnswer[0]), 16'(answers[k]));
    end
    wr(`PCR_PIPE1_OFS, 16'h0080);
    rd(`PCR_PIPE1_OFS, 16'h0040);
    chk("toggleExpected", 16'(toggleExpected[0]), 16'h0001);
    wr(`PCR_PIPE1_OFS, 16'h0180);
    rd(`PCR_PIPE1_OFS, 16'h0000);
    wr(`PCR_PIPE1_OFS, 16'h0001);
    host(1'b1);
    rd(`PCR_PIPE1_OFS, 16'h0021);
    repeat (6) @(posedge ref_clk);
    rd(`PCR_PIPE1_OFS, 16'h0041);
    wr(`PCR_PIPE1_OFS, 16'h0400);
    wr(`PCR_PIPE1_OFS, 16'h0401);
    wr(`PCR_PIPE2_OFS, 16'h0401);
    rd(`PCR_PIPE2_OFS, 16'h0401);
    chk("pipeAnswer", 16'(pipeAnswer[0]), 16'h0000);
    chk("pipeAnswer", 16'(pipeAnswer[1]), 16'h0002);
    host(1'b0);
    repeat (3) @(posedge ref_clk);
    chk("nrCount", 16'(nrCount), 16'h0001);
    wr(`PCR_PIPE1_OFS, 16'h0100);
    ev(0, AVAIL);
    rd(`PCR_PIPE1_OFS, 16'hC000);
    ev(0, RDONE);
    rd(`PCR_PIPE1_OFS, 16'h0000);
    ev(2, AVAIL);
    ev(2, RDONE);
    rd(`PCR_PIPE3_OFS, 16'hC000);
    ev(2, CLRCMD);
    rd(`PCR_PIPE3_OFS, 16'h0000);
    ev(1, SPACE);
    rd(`PCR_PIPE2_OFS, 16'h8401);
    @(posedge ref_clk) drv[1].txDataPending <= 1'b1;
    rd(`PCR_PIPE2_OFS, 16'hC401);
    ev(1, WDONE);
    rd(`PCR_PIPE2_OFS, 16'h4401);
    ev(0, OVER);
    rd(`PCR_PIPE1_OFS, 16'h0003);
    @(posedge ref_clk) busResetSeen <= 1'b1;
    @(posedge ref_clk) busResetSeen <= 1'b0;
    rd(`PCR_PIPE1_OFS, 16'h0000);
    ev(1, SPACE);
    wr(`PCR_PIPE2_OFS, 16'h0200);
    rd(`PCR_PIPE2_OFS, 16'h0200);
    chk("bufferInit", 16'(bufferInit[1]), 16'h0001);
    summarize();
  end
endmodule : pipe_control_register_test
`default_nettype wire
